// [rtl/dcm_regs.sv]
`timescale 1ns/1ns
// Functional notes
// - Command and monitor words are reachable only from the serial link, never from the panel.
// - Run control from the link acts only with serial operation selected and link enable on.
// - With no input assigned to link enable, link enable counts as always on.
// - Signed frequency spans -20000 to 20000, full scale being maximum frequency, sign giving direction.
// - Once the signed frequency word is written, the hertz frequency word is ignored.
// - A one-to-zero change of the run word reset bit fires an alarm reset, alarm or not.
// - Frequency and run words store any value; only the signed frequency sent to the drive is clamped.
// - Out-of-range writes to time and torque words raise a range error and leave the word as it was.
// - Torque word value 7FFF hex selects the special 999 setting.
// - Digital output terminals follow the remote digital output word bit for bit.
// - Configurable run word bits act only where an input function is assigned.
// - Remote analog output takes -20000 to 20000 for -100 to 100 percent.
// - Driving torque takes 2000 to 20000 or 999; braking torque also takes zero.
// - Output current monitors report 0 to 20000 with 10000 as rated current.
// - Read holding, preset single and preset multiple are served, at most 16 registers for read and preset multiple, exactly one for preset single.
// - Address high byte is the group code, low byte the parameter number 0 to 99.
module dcm_regs (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// register access from the message layer
	input wire dcm_pkg::dcm_req_s req,
	output dcm_pkg::dcm_rsp_s rsp,
	// drive configuration and inputs
	input wire logic serial_op_select,
	input wire logic link_enable_assigned,
	input wire logic link_enable_input,
	input wire logic [8:0] input_function_params,
	input wire logic alarm_event,
	input wire dcm_pkg::dcm_live_s live,
	input wire dcm_pkg::dcm_info_s info,
	// commands to the drive
	output dcm_pkg::dcm_cmd_s cmd
);
	typedef struct packed {
		logic [15:0] freq_signed;
		logic [15:0] freq_hz;
		logic [15:0] run_word;
		logic [15:0] dout;
		logic [15:0] accel;
		logic [15:0] decel;
		logic [15:0] tq_drv;
		logic [15:0] tq_brk;
		logic [15:0] aout;
		logic signed_written;
		logic le_meta;
		logic le_sync;
		dcm_pkg::dcm_live_s snap;
		dcm_pkg::dcm_rsp_s rsp;
		dcm_pkg::dcm_cmd_s cmd;
	} dcm_state_s;

	dcm_state_s q;
	dcm_state_s d;

	function automatic logic in_signed_range(input logic [15:0] v);
		in_signed_range = ($signed(v) <= $signed(dcm_pkg::FREQ_POS_LIMIT)) &&
			($signed(v) >= $signed(dcm_pkg::FREQ_NEG_LIMIT));
	endfunction

	function automatic logic [15:0] clamp_signed(input logic [15:0] v);
		if ($signed(v) > $signed(dcm_pkg::FREQ_POS_LIMIT)) begin
			clamp_signed = dcm_pkg::FREQ_POS_LIMIT;
		end else if ($signed(v) < $signed(dcm_pkg::FREQ_NEG_LIMIT)) begin
			clamp_signed = dcm_pkg::FREQ_NEG_LIMIT;
		end else begin
			clamp_signed = v;
		end
	endfunction

	function automatic logic torque_ok(input logic [15:0] v, input logic allow_zero);
		torque_ok = (v == dcm_pkg::TORQUE_SPECIAL) ||
			(allow_zero && v == dcm_pkg::TORQUE_ZERO) ||
			(v >= dcm_pkg::TORQUE_MIN && v <= dcm_pkg::TORQUE_MAX);
	endfunction

	function automatic logic [15:0] clamp_current(input logic [15:0] v);
		clamp_current = (v > dcm_pkg::CURRENT_MAX) ? dcm_pkg::CURRENT_MAX : v;
	endfunction

	// returns {hit, data}
	function automatic logic [16:0] read_word(input logic [15:0] a, input dcm_state_s s,
			input dcm_pkg::dcm_live_s m, input dcm_pkg::dcm_info_s f);
		read_word = 17'h00000;
		unique case (a)
			dcm_pkg::OFS_FREQ_CMD_SIGNED: read_word = {1'b1, s.freq_signed};
			dcm_pkg::OFS_FREQ_CMD_HZ: read_word = {1'b1, s.freq_hz};
			dcm_pkg::OFS_RUN_COMMAND_WORD: read_word = {1'b1, s.run_word};
			dcm_pkg::OFS_REMOTE_DIGITAL_OUT: read_word = {1'b1, s.dout};
			dcm_pkg::OFS_ACCEL_TIME: read_word = {1'b1, s.accel};
			dcm_pkg::OFS_DECEL_TIME: read_word = {1'b1, s.decel};
			dcm_pkg::OFS_TORQUE_LIMIT_DRIVING: read_word = {1'b1, s.tq_drv};
			dcm_pkg::OFS_TORQUE_LIMIT_BRAKING: read_word = {1'b1, s.tq_brk};
			dcm_pkg::OFS_REMOTE_ANALOG_OUT: read_word = {1'b1, s.aout};
			dcm_pkg::OFS_FINAL_FREQ_CMD_SIGNED: read_word = {1'b1, m.final_freq_signed};
			dcm_pkg::OFS_FINAL_FREQ_CMD_HZ: read_word = {1'b1, m.final_freq_hz};
			dcm_pkg::OFS_ACTUAL_FREQ_SIGNED: read_word = {1'b1, m.actual_freq};
			dcm_pkg::OFS_ACTUAL_TORQUE: read_word = {1'b1, m.actual_torque};
			dcm_pkg::OFS_TORQUE_CURRENT: read_word = {1'b1, m.torque_current};
			dcm_pkg::OFS_OUTPUT_FREQ_HZ: read_word = {1'b1, m.output_freq};
			dcm_pkg::OFS_MOTOR_OUTPUT_POWER: read_word = {1'b1, m.motor_power};
			dcm_pkg::OFS_OUTPUT_CURRENT_RMS: read_word = {1'b1, clamp_current(m.output_current)};
			dcm_pkg::OFS_OUTPUT_VOLTAGE_RMS: read_word = {1'b1, m.output_voltage};
			dcm_pkg::OFS_FINAL_RUN_COMMAND: read_word = {1'b1, m.final_run};
			dcm_pkg::OFS_OPERATING_STATE: read_word = {1'b1, m.op_state};
			dcm_pkg::OFS_DIGITAL_OUT_STATE: read_word = {1'b1, m.dout_state};
			dcm_pkg::OFS_FAULT_RECORD_0: read_word = {1'b1, f.fault[0]};
			dcm_pkg::OFS_FAULT_RECORD_1: read_word = {1'b1, f.fault[1]};
			dcm_pkg::OFS_FAULT_RECORD_2: read_word = {1'b1, f.fault[2]};
			dcm_pkg::OFS_FAULT_RECORD_3: read_word = {1'b1, f.fault[3]};
			dcm_pkg::OFS_RUN_HOURS: read_word = {1'b1, m.run_hours};
			dcm_pkg::OFS_DC_LINK_VOLTAGE: read_word = {1'b1, m.dc_link};
			dcm_pkg::OFS_MODEL_TYPE_WORD: read_word = {1'b1, f.model_type};
			dcm_pkg::OFS_CAPACITY_CODE: read_word = {1'b1, f.capacity};
			dcm_pkg::OFS_FIRMWARE_VERSION: read_word = {1'b1, f.fw_version};
			dcm_pkg::OFS_LINK_ERROR_CODE: read_word = {1'b1, f.link_error};
			dcm_pkg::OFS_ALARM_FREQ_CMD_SIGNED: read_word = {1'b1, s.snap.final_freq_signed};
			dcm_pkg::OFS_ALARM_FREQ_CMD_HZ: read_word = {1'b1, s.snap.final_freq_hz};
			dcm_pkg::OFS_ALARM_ACTUAL_FREQ: read_word = {1'b1, s.snap.actual_freq};
			dcm_pkg::OFS_ALARM_ACTUAL_TORQUE: read_word = {1'b1, s.snap.actual_torque};
			dcm_pkg::OFS_ALARM_TORQUE_CURRENT: read_word = {1'b1, s.snap.torque_current};
			dcm_pkg::OFS_ALARM_OUTPUT_FREQ: read_word = {1'b1, s.snap.output_freq};
			dcm_pkg::OFS_ALARM_MOTOR_OUTPUT: read_word = {1'b1, s.snap.motor_power};
			dcm_pkg::OFS_ALARM_OUTPUT_CURRENT: read_word = {1'b1, clamp_current(s.snap.output_current)};
			dcm_pkg::OFS_ALARM_OUTPUT_VOLTAGE: read_word = {1'b1, s.snap.output_voltage};
			dcm_pkg::OFS_ALARM_RUN_COMMAND: read_word = {1'b1, s.snap.final_run};
			dcm_pkg::OFS_ALARM_OPERATING_STATE: read_word = {1'b1, s.snap.op_state};
			dcm_pkg::OFS_ALARM_DIGITAL_OUT_STATE: read_word = {1'b1, s.snap.dout_state};
			dcm_pkg::OFS_ALARM_RUN_HOURS: read_word = {1'b1, s.snap.run_hours};
			dcm_pkg::OFS_ALARM_DC_LINK_VOLTAGE: read_word = {1'b1, s.snap.dc_link};
			dcm_pkg::OFS_ALARM_INTERNAL_TEMP: read_word = {1'b1, s.snap.internal_temp};
			dcm_pkg::OFS_ALARM_HEATSINK_TEMP: read_word = {1'b1, s.snap.heatsink_temp};
			dcm_pkg::OFS_MAIN_CAPACITOR_LIFE: read_word = {1'b1, f.cap_life};
			default: read_word = 17'h00000;
		endcase
	endfunction

	logic link_en;
	logic run_en;
	logic is_write;
	logic [16:0] rd;
	logic [7:0] grp;
	logic [7:0] num;
	logic [7:0] exc;

	always_comb begin
		d = q;
		rd = read_word(req.addr, q, live, info);
		grp = req.addr[15:8];
		num = req.addr[7:0];
		is_write = (req.fn == dcm_pkg::FN_PRESET_SINGLE) || (req.fn == dcm_pkg::FN_PRESET_MULTIPLE);
		exc = dcm_pkg::EXC_NONE;
		d.rsp.valid = 1'b0;
		d.rsp.exc = dcm_pkg::EXC_NONE;
		d.rsp.rdata = 16'h0000;
		// link enable pin crosses in through two flops
		d.le_meta = link_enable_input;
		d.le_sync = q.le_meta;
		link_en = !link_enable_assigned || q.le_sync;
		run_en = serial_op_select && link_en;
		if (alarm_event) begin
			d.snap = live;
		end
		if (req.valid) begin
			if (req.from_panel) begin
				exc = dcm_pkg::EXC_ADDRESS;
			end else if (!is_write && req.fn != dcm_pkg::FN_READ_HOLDING) begin
				exc = dcm_pkg::EXC_FUNCTION;
			end else if (req.count == 5'h00 || req.count > dcm_pkg::MAX_REGS ||
					(req.fn == dcm_pkg::FN_PRESET_SINGLE && req.count != 5'h01)) begin
				exc = dcm_pkg::EXC_VALUE;
			end else if (num > dcm_pkg::PARAM_MAX ||
					(grp != dcm_pkg::GRP_CMD && grp != dcm_pkg::GRP_MON) || !rd[16]) begin
				exc = dcm_pkg::EXC_ADDRESS;
			end else if (is_write && grp == dcm_pkg::GRP_MON) begin
				exc = dcm_pkg::EXC_READ_ONLY;
			end else if (is_write) begin
				unique case (req.addr)
					dcm_pkg::OFS_FREQ_CMD_SIGNED: begin
						d.freq_signed = req.wdata;
						d.signed_written = 1'b1;
					end
					dcm_pkg::OFS_FREQ_CMD_HZ: d.freq_hz = req.wdata;
					dcm_pkg::OFS_RUN_COMMAND_WORD: d.run_word = req.wdata;
					dcm_pkg::OFS_REMOTE_DIGITAL_OUT: d.dout = req.wdata;
					dcm_pkg::OFS_ACCEL_TIME, dcm_pkg::OFS_DECEL_TIME: begin
						if (req.wdata < dcm_pkg::TIME_MIN || req.wdata > dcm_pkg::TIME_MAX) begin
							exc = dcm_pkg::EXC_VALUE;
						end else if (req.addr == dcm_pkg::OFS_ACCEL_TIME) begin
							d.accel = req.wdata;
						end else begin
							d.decel = req.wdata;
						end
					end
					dcm_pkg::OFS_TORQUE_LIMIT_DRIVING: begin
						if (torque_ok(req.wdata, 1'b0)) begin
							d.tq_drv = req.wdata;
						end else begin
							exc = dcm_pkg::EXC_VALUE;
						end
					end
					dcm_pkg::OFS_TORQUE_LIMIT_BRAKING: begin
						if (torque_ok(req.wdata, 1'b1)) begin
							d.tq_brk = req.wdata;
						end else begin
							exc = dcm_pkg::EXC_VALUE;
						end
					end
					dcm_pkg::OFS_REMOTE_ANALOG_OUT: begin
						if (in_signed_range(req.wdata)) begin
							d.aout = req.wdata;
						end else begin
							exc = dcm_pkg::EXC_VALUE;
						end
					end
					default: exc = dcm_pkg::EXC_ADDRESS;
				endcase
			end
			d.rsp.valid = 1'b1;
			d.rsp.exc = exc;
			if (exc == dcm_pkg::EXC_NONE && !is_write) begin
				d.rsp.rdata = rd[15:0];
			end
		end
		// drive-facing commands
		d.cmd.run_fwd = run_en && d.run_word[dcm_pkg::RUN_FWD_BIT];
		d.cmd.run_rev = run_en && d.run_word[dcm_pkg::RUN_REV_BIT];
		d.cmd.cfg_bits = d.run_word[dcm_pkg::RUN_CFG_LSB +: 9] & input_function_params;
		d.cmd.alarm_reset = q.run_word[dcm_pkg::RUN_RST_BIT] &&
			!d.run_word[dcm_pkg::RUN_RST_BIT];
		d.cmd.use_hz = !d.signed_written;
		d.cmd.freq_signed = clamp_signed(d.freq_signed);
		d.cmd.freq_hz = d.freq_hz;
		d.cmd.accel = d.accel;
		d.cmd.decel = d.decel;
		d.cmd.tq_drv = d.tq_drv;
		d.cmd.tq_brk = d.tq_brk;
		d.cmd.tq_drv_special = (d.tq_drv == dcm_pkg::TORQUE_SPECIAL);
		d.cmd.tq_brk_special = (d.tq_brk == dcm_pkg::TORQUE_SPECIAL);
		d.cmd.dout = d.dout;
		d.cmd.aout = d.aout;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q.freq_signed <= dcm_pkg::RST_CMD_WORD;
			q.freq_hz <= dcm_pkg::RST_CMD_WORD;
			q.run_word <= dcm_pkg::RST_CMD_WORD;
			q.dout <= dcm_pkg::RST_CMD_WORD;
			q.accel <= dcm_pkg::RST_TIME;
			q.decel <= dcm_pkg::RST_TIME;
			q.tq_drv <= dcm_pkg::RST_TORQUE;
			q.tq_brk <= dcm_pkg::RST_TORQUE;
			q.aout <= dcm_pkg::RST_CMD_WORD;
			q.signed_written <= 1'b0;
			q.le_meta <= 1'b0;
			q.le_sync <= 1'b0;
			q.snap <= '0;
			q.rsp <= '0;
			q.cmd <= '0;
		end else begin
			q <= d;
		end
	end

	assign rsp = q.rsp;
	assign cmd = q.cmd;
endmodule

// [common/dcm_pkg.sv]
package dcm_pkg;
	// address layout
	localparam logic [7:0] GRP_CMD = 8'h07;
	localparam logic [7:0] GRP_MON = 8'h08;
	localparam logic [7:0] PARAM_MAX = 8'h63;
	// command words
	localparam logic [15:0] OFS_FREQ_CMD_SIGNED = 16'h0701;
	localparam logic [15:0] OFS_FREQ_CMD_HZ = 16'h0705;
	localparam logic [15:0] OFS_RUN_COMMAND_WORD = 16'h0706;
	localparam logic [15:0] OFS_REMOTE_DIGITAL_OUT = 16'h0707;
	localparam logic [15:0] OFS_ACCEL_TIME = 16'h0708;
	localparam logic [15:0] OFS_DECEL_TIME = 16'h0709;
	localparam logic [15:0] OFS_TORQUE_LIMIT_DRIVING = 16'h070A;
	localparam logic [15:0] OFS_TORQUE_LIMIT_BRAKING = 16'h070B;
	localparam logic [15:0] OFS_REMOTE_ANALOG_OUT = 16'h070C;
	// monitor words
	localparam logic [15:0] OFS_FINAL_FREQ_CMD_SIGNED = 16'h0801;
	localparam logic [15:0] OFS_FINAL_FREQ_CMD_HZ = 16'h0805;
	localparam logic [15:0] OFS_ACTUAL_FREQ_SIGNED = 16'h0806;
	localparam logic [15:0] OFS_ACTUAL_TORQUE = 16'h0807;
	localparam logic [15:0] OFS_TORQUE_CURRENT = 16'h0808;
	localparam logic [15:0] OFS_OUTPUT_FREQ_HZ = 16'h0809;
	localparam logic [15:0] OFS_MOTOR_OUTPUT_POWER = 16'h080A;
	localparam logic [15:0] OFS_OUTPUT_CURRENT_RMS = 16'h080B;
	localparam logic [15:0] OFS_OUTPUT_VOLTAGE_RMS = 16'h080C;
	localparam logic [15:0] OFS_FINAL_RUN_COMMAND = 16'h080D;
	localparam logic [15:0] OFS_OPERATING_STATE = 16'h080E;
	localparam logic [15:0] OFS_DIGITAL_OUT_STATE = 16'h080F;
	localparam logic [15:0] OFS_FAULT_RECORD_0 = 16'h0810;
	localparam logic [15:0] OFS_FAULT_RECORD_1 = 16'h0811;
	localparam logic [15:0] OFS_FAULT_RECORD_2 = 16'h0812;
	localparam logic [15:0] OFS_FAULT_RECORD_3 = 16'h0813;
	localparam logic [15:0] OFS_RUN_HOURS = 16'h0814;
	localparam logic [15:0] OFS_DC_LINK_VOLTAGE = 16'h0815;
	localparam logic [15:0] OFS_MODEL_TYPE_WORD = 16'h0817;
	localparam logic [15:0] OFS_CAPACITY_CODE = 16'h0818;
	localparam logic [15:0] OFS_FIRMWARE_VERSION = 16'h0819;
	localparam logic [15:0] OFS_LINK_ERROR_CODE = 16'h081A;
	localparam logic [15:0] OFS_ALARM_FREQ_CMD_SIGNED = 16'h081B;
	localparam logic [15:0] OFS_ALARM_FREQ_CMD_HZ = 16'h081F;
	localparam logic [15:0] OFS_ALARM_ACTUAL_FREQ = 16'h0820;
	localparam logic [15:0] OFS_ALARM_ACTUAL_TORQUE = 16'h0821;
	localparam logic [15:0] OFS_ALARM_TORQUE_CURRENT = 16'h0822;
	localparam logic [15:0] OFS_ALARM_OUTPUT_FREQ = 16'h0823;
	localparam logic [15:0] OFS_ALARM_MOTOR_OUTPUT = 16'h0824;
	localparam logic [15:0] OFS_ALARM_OUTPUT_CURRENT = 16'h0825;
	localparam logic [15:0] OFS_ALARM_OUTPUT_VOLTAGE = 16'h0826;
	localparam logic [15:0] OFS_ALARM_RUN_COMMAND = 16'h0827;
	localparam logic [15:0] OFS_ALARM_OPERATING_STATE = 16'h0828;
	localparam logic [15:0] OFS_ALARM_DIGITAL_OUT_STATE = 16'h0829;
	localparam logic [15:0] OFS_ALARM_RUN_HOURS = 16'h082A;
	localparam logic [15:0] OFS_ALARM_DC_LINK_VOLTAGE = 16'h082B;
	localparam logic [15:0] OFS_ALARM_INTERNAL_TEMP = 16'h082C;
	localparam logic [15:0] OFS_ALARM_HEATSINK_TEMP = 16'h082D;
	localparam logic [15:0] OFS_MAIN_CAPACITOR_LIFE = 16'h082E;
	// transaction codes and answers
	localparam logic [7:0] FN_READ_HOLDING = 8'h03;
	localparam logic [7:0] FN_PRESET_SINGLE = 8'h06;
	localparam logic [7:0] FN_PRESET_MULTIPLE = 8'h10;
	localparam logic [4:0] MAX_REGS = 5'h10;
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_FUNCTION = 8'h01;
	localparam logic [7:0] EXC_ADDRESS = 8'h02;
	localparam logic [7:0] EXC_VALUE = 8'h03;
	localparam logic [7:0] EXC_READ_ONLY = 8'h04;
	// value limits
	localparam logic [15:0] FREQ_POS_LIMIT = 16'h4E20;
	localparam logic [15:0] FREQ_NEG_LIMIT = 16'hB1E0;
	localparam logic [15:0] TIME_MIN = 16'h0001;
	localparam logic [15:0] TIME_MAX = 16'h8CA0;
	localparam logic [15:0] TORQUE_MIN = 16'h07D0;
	localparam logic [15:0] TORQUE_MAX = 16'h4E20;
	localparam logic [15:0] TORQUE_SPECIAL = 16'h7FFF;
	localparam logic [15:0] TORQUE_ZERO = 16'h0000;
	localparam logic [15:0] CURRENT_MAX = 16'h4E20;
	// run command word bit positions
	localparam int RUN_FWD_BIT = 0;
	localparam int RUN_REV_BIT = 1;
	localparam int RUN_CFG_LSB = 2;
	localparam int RUN_RST_BIT = 15;
	// values after reset
	localparam logic [15:0] RST_CMD_WORD = 16'h0000;
	localparam logic [15:0] RST_TIME = 16'h0064;
	localparam logic [15:0] RST_TORQUE = 16'h7FFF;

	typedef struct packed {
		logic valid;
		logic from_panel;
		logic [7:0] fn;
		logic [4:0] count;
		logic [15:0] addr;
		logic [15:0] wdata;
	} dcm_req_s;

	typedef struct packed {
		logic valid;
		logic [7:0] exc;
		logic [15:0] rdata;
	} dcm_rsp_s;

	typedef struct packed {
		logic [15:0] final_freq_signed;
		logic [15:0] final_freq_hz;
		logic [15:0] actual_freq;
		logic [15:0] actual_torque;
		logic [15:0] torque_current;
		logic [15:0] output_freq;
		logic [15:0] motor_power;
		logic [15:0] output_current;
		logic [15:0] output_voltage;
		logic [15:0] final_run;
		logic [15:0] op_state;
		logic [15:0] dout_state;
		logic [15:0] run_hours;
		logic [15:0] dc_link;
		logic [15:0] internal_temp;
		logic [15:0] heatsink_temp;
	} dcm_live_s;

	typedef struct packed {
		logic [3:0][15:0] fault;
		logic [15:0] model_type;
		logic [15:0] capacity;
		logic [15:0] fw_version;
		logic [15:0] link_error;
		logic [15:0] cap_life;
	} dcm_info_s;

	typedef struct packed {
		logic run_fwd;
		logic run_rev;
		logic [8:0] cfg_bits;
		logic alarm_reset;
		logic use_hz;
		logic [15:0] freq_signed;
		logic [15:0] freq_hz;
		logic [15:0] accel;
		logic [15:0] decel;
		logic [15:0] tq_drv;
		logic [15:0] tq_brk;
		logic tq_drv_special;
		logic tq_brk_special;
		logic [15:0] dout;
		logic [15:0] aout;
	} dcm_cmd_s;
endpackage

// [test/dcm_regs_checker.sv]
`timescale 1ns/1ns
module dcm_regs_checker (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// watched ports
	input wire dcm_pkg::dcm_req_s req,
	input wire dcm_pkg::dcm_rsp_s rsp,
	input wire logic serial_op_select,
	input wire logic [8:0] input_function_params,
	input wire dcm_pkg::dcm_cmd_s cmd
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	logic wr_ok;
	assign wr_ok = req.valid && !req.from_panel && req.fn == dcm_pkg::FN_PRESET_SINGLE
		&& req.count == 5'h01;
	a_rsp_next_cycle: assert property (req.valid |=> rsp.valid)
		else $error("no answer one cycle after a request");
	a_rsp_quiet: assert property (!req.valid |=> !rsp.valid)
		else $error("answer without a request");
	a_panel_refused: assert property (req.valid && req.from_panel
		|=> rsp.exc == dcm_pkg::EXC_ADDRESS && rsp.rdata == 16'h0000)
		else $error("panel access not refused");
	a_monitor_write: assert property (wr_ok && req.addr == dcm_pkg::OFS_OUTPUT_CURRENT_RMS
		|=> rsp.exc == dcm_pkg::EXC_READ_ONLY)
		else $error("monitor word write not refused");
	a_dout_follows: assert property (wr_ok && req.addr == dcm_pkg::OFS_REMOTE_DIGITAL_OUT
		|=> cmd.dout == $past(req.wdata))
		else $error("digital outputs do not follow written word");
	a_accel_reject: assert property (wr_ok && req.addr == dcm_pkg::OFS_ACCEL_TIME
		&& req.wdata == 16'h0000 |=> rsp.exc == dcm_pkg::EXC_VALUE && $stable(cmd.accel))
		else $error("zero acceleration time accepted");
	a_special_flag: assert property (cmd.tq_drv_special == (cmd.tq_drv == 16'h7FFF))
		else $error("torque special flag wrong");
	a_run_gated: assert property (cmd.run_fwd |-> $past(serial_op_select))
		else $error("run without serial operation selected");
	a_cfg_masked: assert property ((cmd.cfg_bits & ~$past(input_function_params)) == 9'h000)
		else $error("unassigned input bit active");
	a_reset_pulse: assert property ($rose(cmd.alarm_reset) |=> !cmd.alarm_reset)
		else $error("alarm reset longer than one cycle");
	a_freq_clamp: assert property ($signed(cmd.freq_signed) <= 20000
		&& $signed(cmd.freq_signed) >= -20000)
		else $error("frequency to drive beyond full scale");
	cover property (cmd.alarm_reset);
	cover property (rsp.valid && rsp.exc == dcm_pkg::EXC_VALUE);
	cover property (cmd.run_fwd);
endmodule
bind dcm_regs dcm_regs_checker u_dcm_regs_checker (.clk(clk), .nrst(nrst), .req(req),
	.rsp(rsp), .serial_op_select(serial_op_select),
	.input_function_params(input_function_params), .cmd(cmd));

// [test/dcm_master.sv]
`timescale 1ns/1ns
module dcm_master (
	// clock
	input wire logic clk,
	// word requests to the bank
	output dcm_pkg::dcm_req_s req
);
	initial req = '0;
	// one word per request, held up to the taking edge
	task automatic xfer(input logic [7:0] fn, input logic [4:0] cnt, input logic [7:0] grp,
		input logic [7:0] num, input logic [15:0] wd, input logic panel);
		@(posedge clk);
		#1;
		req = '{valid: 1'b1, from_panel: panel, fn: fn, count: cnt, addr: {grp, num}, wdata: wd};
		@(posedge clk);
		#1;
		req.valid = 1'b0;
		req.wdata = ~wd;
	endtask
endmodule

// [test/dcm_regs_test.sv]
`timescale 1ns/1ns
module dcm_regs_test;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic serial_op_select = 1'b0;
	logic link_enable_assigned = 1'b0;
	logic link_enable_input = 1'b0;
	logic [8:0] input_function_params = 9'h000;
	logic alarm_event = 1'b0;
	dcm_pkg::dcm_live_s live = '0;
	dcm_pkg::dcm_info_s info = '0;
	dcm_pkg::dcm_req_s req;
	dcm_pkg::dcm_rsp_s rsp;
	dcm_pkg::dcm_cmd_s cmd;
	int fails = 0;
	int n_checks = 0;
	int cycles = 0;
	int n_rst = 0;
	int seed = 25242;
	logic [23:0] expq[$];
	logic [15:0] v;
	logic [39:0] tbl [14] = '{40'h0708000003, 40'h07088CA103, 40'h07088CA000,
		40'h0709000100, 40'h070A000003, 40'h070A07CF03, 40'h070A07D000, 40'h070A4E2103,
		40'h070B000000, 40'h070B07CF03, 40'h070A7FFF00, 40'h070C4E2103, 40'h070CB1E000,
		40'h070CB1DF03};

	initial forever #2 clk = ~clk;
	dcm_master u_master (.clk(clk), .req(req));
	dcm_regs u_dcm_regs (.clk(clk), .nrst(nrst), .req(req), .rsp(rsp),
		.serial_op_select(serial_op_select), .link_enable_assigned(link_enable_assigned),
		.link_enable_input(link_enable_input), .input_function_params(input_function_params),
		.alarm_event(alarm_event), .live(live), .info(info), .cmd(cmd));

	task automatic chk_rsp(input logic [23:0] exp, input logic [23:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("FAIL rsp expected %h seen %h", exp, got);
		end
	endtask
	task automatic chk_cmd(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic test_done;
		// every noted answer must have been seen
		if (expq.size() != 0) begin
			fails++;
			$display("FAIL rsp_queue expected 0 seen %0d", expq.size());
		end
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic op(input logic [7:0] fn, input logic [15:0] a, input logic [15:0] wd,
		input logic [7:0] exc, input logic [15:0] rd, input logic [4:0] cnt = 5'h01,
		input logic panel = 1'b0);
		expq.push_back({exc, rd});
		u_master.xfer(fn, cnt, a[15:8], a[7:0], wd, panel);
		@(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] wd, input logic [7:0] exc);
		op(8'h06, a, wd, exc, 16'h0000);
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		op(8'h03, a, 16'h0000, 8'h00, exp);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// responses are matched against notes in request order
	always @(negedge clk) begin
		if (cmd.alarm_reset === 1'b1)
			n_rst++;
		if (rsp.valid === 1'b1) begin
			if (expq.size() == 0) begin
				fails++;
				$display("FAIL rsp expected none seen %h", {rsp.exc, rsp.rdata});
			end else
				chk_rsp(expq.pop_front(), {rsp.exc, rsp.rdata});
		end
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			test_done;
		end
	end

	initial begin
		for (int i = 0; i < 8; i++)
			live[i*32 +: 32] = $random(seed);
		for (int i = 0; i < 4; i++)
			info[i*32 +: 32] = $random(seed);
		live.output_current = 16'($unsigned($random(seed)) % 20001);
		input_function_params = 9'($random(seed));
		wait_cyc(10);
		nrst = 1'b1;
		rd(16'h0708, 16'h0064);
		rd(16'h070A, 16'h7FFF);
		chk_cmd("tq_special", 16'h0001, 16'(cmd.tq_drv_special));
		wr(16'h0707, 16'h0011, 8'h00);
		chk_cmd("dout", 16'h0011, cmd.dout);
		op(8'h03, 16'h080B, 16'h0000, 8'h02, 16'h0000, 5'h01, 1'b1);
		op(8'h04, 16'h0708, 16'h0000, 8'h01, 16'h0000);
		op(8'h03, 16'h0708, 16'h0000, 8'h03, 16'h0000, 5'h11);
		op(8'h03, 16'h0708, 16'h0000, 8'h00, 16'h0064, 5'h10);
		op(8'h03, 16'h0764, 16'h0000, 8'h02, 16'h0000);
		op(8'h03, 16'h0901, 16'h0000, 8'h02, 16'h0000);
		wr(16'h080B, 16'h1234, 8'h04);
		rd(16'h080B, live.output_current);
		for (int i = 0; i < 14; i++)
			wr(tbl[i][39:24], tbl[i][23:8], tbl[i][7:0]);
		chk_cmd("accel", 16'h8CA0, cmd.accel);
		chk_cmd("decel", 16'h0001, cmd.decel);
		chk_cmd("tq_drv", 16'h7FFF, cmd.tq_drv);
		chk_cmd("tq_brk", 16'h0000, cmd.tq_brk);
		chk_cmd("aout", 16'hB1E0, cmd.aout);
		chk_cmd("tq_brk_special", 16'h0000, 16'(cmd.tq_brk_special));
		op(8'h10, 16'h0709, 16'h0032, 8'h00, 16'h0000, 5'h02);
		chk_cmd("decel", 16'h0032, cmd.decel);
		wr(16'h0705, 16'h1770, 8'h00);
		chk_cmd("use_hz", 16'h0001, 16'(cmd.use_hz));
		wr(16'h0701, 16'h61A8, 8'h00);
		wr(16'h0705, 16'h0BB8, 8'h00);
		rd(16'h0701, 16'h61A8);
		chk_cmd("freq_hz", 16'h0BB8, cmd.freq_hz);
		chk_cmd("freq", 16'h4E20, cmd.freq_signed);
		chk_cmd("use_hz", 16'h0000, 16'(cmd.use_hz));
		serial_op_select = 1'b1;
		wr(16'h0706, 16'h87FD, 8'h00);
		chk_cmd("run_fwd", 16'h0001, 16'(cmd.run_fwd));
		chk_cmd("cfg", 16'(input_function_params), 16'(cmd.cfg_bits));
		v = 16'(n_rst);
		wr(16'h0706, 16'h0001, 8'h00);
		wr(16'h0706, 16'h0001, 8'h00);
		chk_cmd("alarm_resets", v + 16'h0001, 16'(n_rst));
		link_enable_assigned = 1'b1;
		wait_cyc(4);
		chk_cmd("run_fwd", 16'h0000, 16'(cmd.run_fwd));
		link_enable_input = 1'b1;
		wait_cyc(4);
		chk_cmd("run_fwd", 16'h0001, 16'(cmd.run_fwd));
		wr(16'h0706, 16'h0003, 8'h00);
		chk_cmd("run_rev", 16'h0001, 16'(cmd.run_rev));
		serial_op_select = 1'b0;
		wait_cyc(2);
		chk_cmd("run_fwd", 16'h0000, 16'(cmd.run_fwd));
		chk_cmd("run_rev", 16'h0000, 16'(cmd.run_rev));
		alarm_event = 1'b1;
		wait_cyc(1);
		alarm_event = 1'b0;
		v = live.output_current;
		live.output_current = 16'hFFFF;
		rd(16'h080B, 16'h4E20);
		rd(16'h0825, v);
		test_done;
	end
endmodule
